// File: sacs_defs.svh
`ifndef SACS_DEFS_SVH
`define SACS_DEFS_SVH
`define SACS_OFS_SC 4'h0
`define SACS_OFS_RH 4'h4
`define SACS_OFS_RL 4'h8
`define SACS_OFS_CLK 4'hc
`define SACS_SC_CONVERSION_COMPLETE_FLAG 7
`define SACS_SC_INTERRUPT_ENABLE_BIT 6
`define SACS_SC_CONT 5
`define SACS_SC_CH_HI 4
`define SACS_SC_CH_LO 0
`define SACS_CH_OFF 5'h1f
`define SACS_CLK_LPC 7
`define SACS_CLK_DIV_HI 6
`define SACS_CLK_DIV_LO 5
`define SACS_CLK_ICLK 4
`define SACS_CLK_MODE_HI 3
`define SACS_CLK_MODE_LO 2
`define SACS_CLK_LSMP 1
`define SACS_CLK_ACLK 0
`define SACS_RST_CH 5'h1f
`define SACS_RST_CLK 8'h00
`define SACS_MODE_8 2'h0
`define SACS_MODE_10 2'h1
`define SACS_SHORT_HALF 7
`define SACS_LONG_HALF 47
`define SACS_SAR_TOP 4'ha
`endif

// File: sacs_pkg.sv
package sacs_pkg;
   typedef enum logic [2:0] {
      SACS_IDLE = 3'b001,
      SACS_SAMPLE = 3'b010,
      SACS_CONV = 3'b100
   } sacs_state_t;
   typedef logic [1:0] sacs_mode_t;
   typedef logic [10:0] sacs_sar_t;
endpackage : sacs_pkg

// File: sacs_top.sv
`timescale 1ns/1ps
`include "sacs_defs.svh"
// Behaviour
// RULE_01 - Status/control write aborts conversion, starts new one unless channel is all ones.
// RULE_02 - Complete flag sets at conversion end; clears on control write or low read.
// RULE_03 - Enabled interrupt rises at conversion end; drops on result read or control write.
// RULE_04 - Continuous bit with valid channel converts repeatedly, updating results each time.
// RULE_05 - Continuous mode stops on reset, stop entry, clock register write, control write.
// RULE_06 - After stop-entry halt, only a status/control write restarts conversions.
// RULE_07 - Continuous bit clear: each valid control write triggers exactly one conversion.
// RULE_08 - Five-bit channel; all ones powers off, isolates input, no extra conversion.
// RULE_09 - Converter drops to low power whenever conversion ends with nothing pending.
// RULE_10 - Unused or reserved channel codes give an undefined result.
// RULE_11 - In 10-bit mode a high read blocks result transfers until low read.
// RULE_12 - Conversions finishing while blocked are discarded, not stored.
// RULE_13 - In 8-bit mode high and low results have no interlock.
// RULE_14 - High result bits carrying no result read as zero.
// RULE_15 - Divider field divides input clock by 1, 2, 4 or 8.
// RULE_16 - Async enable clear: select bit picks bus clock at 1, alternate at 0.
// RULE_17 - Resolution field 00 is 8-bit, 01 is 10-bit, others reserved; reset 8-bit.
// RULE_18 - Long sample bit gives 23.5 converter cycles sampling, else 3.5; code samples until the 24th or 4th converter tick.
// RULE_19 - Async enable uses async clock, runs it only converting, survives stop mode.
// RULE_20 - Low power bit selects reduced power configuration, clear selects high speed.
// RULE_21 - Approximation result is rounded to the selected 8 or 10 bit width.
// RULE_22 - Software keeps bus clock fast enough relative to converter clock.
// RULE_23 - Complete flag sets at every conversion end regardless of interrupt enable.
// RULE_24 - Stop entry without async clock aborts, powers down, keeps last results.
// RULE_25 - 10-bit mode puts two top bits in high register, eight in low.
module sacs_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   input wire logic stop_mode_i,
   input wire logic alt_clk_i,
   input wire logic async_clk_i,
   input wire logic comp_i,
   output logic conv_on_o,
   output logic sample_o,
   output logic input_isolate_o,
   output logic low_power_o,
   output logic async_clk_req_o,
   output logic [4:0] channel_o,
   output sacs_pkg::sacs_sar_t dac_trial_o
);
   import sacs_pkg::*;

   localparam logic [4:0] SHORT_TICKS = 5'((`SACS_SHORT_HALF + 1) / 2);
   localparam logic [4:0] LONG_TICKS = 5'((`SACS_LONG_HALF + 1) / 2);

   sacs_state_t state_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [4:0] ch_q;
   logic interrupt_enable_bit_q, cont_q, conversion_complete_flag_q, irq_q, lock_q, stop_q;
   logic lpc_q, iclk_q, lsmp_q, aclk_q;
   logic [1:0] div_q;
   sacs_mode_t mode_q;
   logic [7:0] res_hi_q, res_lo_q;
   logic [2:0] alt_s_q, asy_s_q;
   logic [2:0] div_cnt_q;
   logic [4:0] smp_q;
   sacs_sar_t sar_q;
   logic [3:0] bit_q;

   logic acc, wr, rd, sc_wr, clk_wr, rdh, rdl;
   logic start, stop_evt, abort, done, mode10;
   logic tick_in, converter_clock_tick, smp_end;
   logic [2:0] div_m1;
   logic [4:0] smp_last;
   sacs_sar_t sar_fin;
   logic [9:0] r10;
   logic [7:0] r8;

   // Round to width: add the bit below the LSB, saturate at full scale
   function automatic logic [9:0] round10(input sacs_sar_t v);
      logic [10:0] s;
      s = {1'b0, v[10:1]} + {10'h000, v[0]};
      round10 = s[10] ? 10'h3ff : s[9:0];
   endfunction : round10

   function automatic logic [7:0] round8(input sacs_sar_t v);
      logic [8:0] s;
      s = {1'b0, v[10:3]} + {8'h00, v[2]};
      round8 = s[8] ? 8'hff : s[7:0];
   endfunction : round8

   assign acc = cyc_i & stb_i & ~ack_q;
   assign wr = acc & we_i & sel_i[0];
   assign rd = acc & ~we_i;
   assign sc_wr = wr & (adr_i == `SACS_OFS_SC);
   assign clk_wr = wr & (adr_i == `SACS_OFS_CLK);
   assign rdh = rd & (adr_i == `SACS_OFS_RH);
   assign rdl = rd & (adr_i == `SACS_OFS_RL);
   // RULE_01 RULE_07 start on write
   assign start = sc_wr & (dat_i[`SACS_SC_CH_HI:`SACS_SC_CH_LO] != `SACS_CH_OFF);
   // RULE_24 stop entry abort
   assign stop_evt = stop_mode_i & ~stop_q & ~aclk_q;
   assign abort = sc_wr | stop_evt;
   // RULE_17 only 01 means 10-bit
   assign mode10 = (mode_q == `SACS_MODE_10);

   // Bus slave: one wait state, any address answered, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (rd) begin
         case (adr_i)
            `SACS_OFS_SC: dat_q <= {24'h000000, conversion_complete_flag_q, interrupt_enable_bit_q, cont_q, ch_q};
            // RULE_14 unused high bits zero
            `SACS_OFS_RH: dat_q <= {24'h000000, res_hi_q};
            `SACS_OFS_RL: dat_q <= {24'h000000, res_lo_q};
            `SACS_OFS_CLK: dat_q <= {24'h000000, lpc_q, div_q, iclk_q, mode_q, lsmp_q, aclk_q};
            default: dat_q <= 32'h0000_0000;
         endcase
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch_q <= `SACS_RST_CH;
         interrupt_enable_bit_q <= 1'b0;
      end else if (sc_wr) begin
         ch_q <= dat_i[`SACS_SC_CH_HI:`SACS_SC_CH_LO];
         interrupt_enable_bit_q <= dat_i[`SACS_SC_INTERRUPT_ENABLE_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {lpc_q, div_q, iclk_q, mode_q, lsmp_q, aclk_q} <= `SACS_RST_CLK;
      end else if (clk_wr) begin
         lpc_q <= dat_i[`SACS_CLK_LPC];
         div_q <= dat_i[`SACS_CLK_DIV_HI:`SACS_CLK_DIV_LO];
         iclk_q <= dat_i[`SACS_CLK_ICLK];
         mode_q <= dat_i[`SACS_CLK_MODE_HI:`SACS_CLK_MODE_LO];
         lsmp_q <= dat_i[`SACS_CLK_LSMP];
         aclk_q <= dat_i[`SACS_CLK_ACLK];
      end
   end

   // Stop request comes from the system on this clock; only its entry matters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_q <= 1'b0;
      end else begin
         stop_q <= stop_mode_i;
      end
   end

   // Continuous mode flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cont_q <= 1'b0;
      end else if (stop_evt) begin
         // RULE_05 RULE_06 halt until control write
         cont_q <= 1'b0;
      end else if (sc_wr) begin
         // RULE_08 all ones ends continuous mode
         cont_q <= dat_i[`SACS_SC_CONT] & start;
      end else if (clk_wr) begin
         // RULE_05 clock write stops repeat
         cont_q <= 1'b0;
      end
   end

   // Clock pins are asynchronous: two flops, then edge detect on later stages
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alt_s_q <= 3'h0;
         asy_s_q <= 3'h0;
      end else begin
         alt_s_q <= {alt_s_q[1:0], alt_clk_i};
         asy_s_q <= {asy_s_q[1:0], async_clk_i};
      end
   end

   // RULE_16 RULE_19 divider input select
   assign tick_in = aclk_q ? (asy_s_q[1] & ~asy_s_q[2]) :
                    (iclk_q ? 1'b1 : (alt_s_q[1] & ~alt_s_q[2]));

   // RULE_15 divide by 1 2 4 8
   assign div_m1 = 3'((4'h1 << div_q) - 4'h1);
   assign converter_clock_tick = tick_in & (div_cnt_q == div_m1) & (state_q != SACS_IDLE);

   always_ff @(posedge clk_i) begin
      if (rst_i || state_q == SACS_IDLE || abort) begin
         div_cnt_q <= 3'h0;
      end else if (tick_in) begin
         div_cnt_q <= (div_cnt_q == div_m1) ? 3'h0 : div_cnt_q + 3'h1;
      end
   end

   // RULE_18 sampling length
   // Half cycles cannot be made from a tick, so sampling ends on the next whole tick
   assign smp_last = (lsmp_q ? LONG_TICKS : SHORT_TICKS) - 5'h1;
   assign smp_end = (state_q == SACS_SAMPLE) & converter_clock_tick & (smp_q == smp_last);
   assign done = (state_q == SACS_CONV) & converter_clock_tick & (bit_q == 4'h0) & ~abort;

   always_ff @(posedge clk_i) begin
      if (rst_i || state_q != SACS_SAMPLE || abort) begin
         smp_q <= 5'h00;
      end else if (converter_clock_tick) begin
         smp_q <= smp_q + 5'h1;
      end
   end

   // Conversion sequence
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= SACS_IDLE;
      end else if (stop_evt) begin
         // RULE_24 abort into low power
         state_q <= SACS_IDLE;
      end else if (sc_wr) begin
         // RULE_01 abort and restart
         state_q <= start ? SACS_SAMPLE : SACS_IDLE;
      end else begin
         case (state_q)
            SACS_IDLE: state_q <= SACS_IDLE;
            SACS_SAMPLE: begin
               if (smp_end) begin
                  state_q <= SACS_CONV;
               end
            end
            SACS_CONV: begin
               if (done) begin
                  // RULE_04 RULE_09 repeat or power down
                  state_q <= cont_q ? SACS_SAMPLE : SACS_IDLE;
               end
            end
            default: state_q <= SACS_IDLE;
         endcase
      end
   end

   // Successive approximation, one decision per converter tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sar_q <= 11'h000;
         bit_q <= 4'h0;
      end else if (smp_end && !abort) begin
         sar_q <= 11'h400;
         bit_q <= `SACS_SAR_TOP;
      end else if (state_q == SACS_CONV && converter_clock_tick) begin
         if (!comp_i) begin
            sar_q[bit_q] <= 1'b0;
         end
         if (bit_q != 4'h0) begin
            sar_q[bit_q - 4'h1] <= 1'b1;
            bit_q <= bit_q - 4'h1;
         end
      end
   end

   // RULE_21 rounded to mode width
   assign sar_fin = comp_i ? sar_q : (sar_q & 11'h7fe);
   assign r10 = round10(sar_fin);
   assign r8 = round8(sar_fin);

   // RULE_11 RULE_13 read interlock
   always_ff @(posedge clk_i) begin
      if (rst_i || !mode10 || rdl) begin
         lock_q <= 1'b0;
      end else if (rdh) begin
         lock_q <= 1'b1;
      end
   end

   // RULE_10 unused channels store whatever the array returns
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_hi_q <= 8'h00;
         res_lo_q <= 8'h00;
      end else if (done && !lock_q) begin
         // RULE_12 RULE_25 store unless blocked
         if (mode10) begin
            res_hi_q <= {6'h00, r10[9:8]};
            res_lo_q <= r10[7:0];
         end else begin
            res_hi_q <= 8'h00;
            res_lo_q <= r8;
         end
      end
   end

   // RULE_02 RULE_23 complete flag, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conversion_complete_flag_q <= 1'b0;
      end else if (done) begin
         conversion_complete_flag_q <= 1'b1;
      end else if (sc_wr || rdl) begin
         conversion_complete_flag_q <= 1'b0;
      end
   end

   // RULE_03 interrupt, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else if (done && interrupt_enable_bit_q) begin
         irq_q <= 1'b1;
      end else if (sc_wr || rdh || rdl) begin
         irq_q <= 1'b0;
      end
   end

   assign irq_o = irq_q;
   // RULE_08 RULE_09 power and isolation
   assign conv_on_o = ~state_q[0];
   assign sample_o = state_q[1];
   assign input_isolate_o = (ch_q == `SACS_CH_OFF);
   assign channel_o = ch_q;
   // RULE_20 power configuration
   assign low_power_o = lpc_q;
   // RULE_19 generator only while converting
   assign async_clk_req_o = aclk_q & ~state_q[0];
   assign dac_trial_o = sar_q;

   property p_start;
      @(posedge clk_i) disable iff (rst_i) start && !stop_evt |=> state_q == SACS_SAMPLE;
   endproperty
   a_start: assert property (p_start) else $error("write did not start"); // RULE_01

   property p_conversion_complete_flag;
      @(posedge clk_i) disable iff (rst_i) done |=> conversion_complete_flag_q;
   endproperty
   a_conversion_complete_flag: assert property (p_conversion_complete_flag) else $error("complete flag not set"); // RULE_23

   property p_conversion_complete_flag_clr;
      @(posedge clk_i) disable iff (rst_i) rdl && !done |=> !conversion_complete_flag_q;
   endproperty
   a_conversion_complete_flag_clr: assert property (p_conversion_complete_flag_clr) else $error("complete flag not cleared"); // RULE_02

   property p_irq;
      @(posedge clk_i) disable iff (rst_i) done && interrupt_enable_bit_q |=> irq_o ##1 (irq_o || $past(sc_wr || rdh || rdl));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing"); // RULE_03

   property p_cont;
      @(posedge clk_i) disable iff (rst_i) done && cont_q |=> state_q == SACS_SAMPLE;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous repeat missing"); // RULE_04

   property p_single;
      @(posedge clk_i) disable iff (rst_i) done && !cont_q |=> conv_on_o == 1'b0;
   endproperty
   a_single: assert property (p_single) else $error("not idle after single"); // RULE_09

   property p_clkwr;
      @(posedge clk_i) disable iff (rst_i) clk_wr && !sc_wr |=> !cont_q;
   endproperty
   a_clkwr: assert property (p_clkwr) else $error("clock write kept continuous"); // RULE_05

   property p_off;
      @(posedge clk_i) disable iff (rst_i) sc_wr && !start |=> !conv_on_o && input_isolate_o && !cont_q;
   endproperty
   a_off: assert property (p_off) else $error("off code still converting"); // RULE_08

   property p_lock;
      @(posedge clk_i) disable iff (rst_i) done && lock_q |=> $stable(res_lo_q) && $stable(res_hi_q);
   endproperty
   a_lock: assert property (p_lock) else $error("blocked result stored"); // RULE_12

   property p_hi_zero;
      @(posedge clk_i) disable iff (rst_i) done && !lock_q |=> res_hi_q[7:2] == 6'h00;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("high bits not zero"); // RULE_14

   property p_stop;
      @(posedge clk_i) disable iff (rst_i) stop_evt |=> !conv_on_o && $stable(res_lo_q) && !cont_q;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not abort"); // RULE_24
endmodule : sacs_top

// File: sacs_analog_model.sv
`timescale 1ns/1ps
// Ideal comparator seen by the converter's trial word
module sacs_analog_model (
   input wire sacs_pkg::sacs_sar_t dac_trial_i,
   input wire sacs_pkg::sacs_sar_t level_i,
   output logic comp_o
);
   import sacs_pkg::*;
   // Noise-free, so every approximation of one level lands on the same code
   assign comp_o = (level_i >= dac_trial_i);
endmodule : sacs_analog_model

// File: tb_sacs_top.sv
`timescale 1ns/1ps
`include "sacs_defs.svh"
module tb_sacs_top;
   import sacs_pkg::*;
   localparam logic [3:0] SC = `SACS_OFS_SC;
   localparam logic [3:0] RH = `SACS_OFS_RH;
   localparam logic [3:0] RL = `SACS_OFS_RL;
   localparam logic [3:0] CK = `SACS_OFS_CLK;
   logic clk_i, rst_i, cyc, stb, we, stop, alt, asy, comp;
   logic [3:0] adr, sel;
   logic [31:0] dat, dat_o;
   logic ack_o, irq_o, conv_o, smp_o, iso_o, lp_o, areq_o;
   logic [4:0] ch_o;
   logic [7:0] q;
   sacs_sar_t trial, level;
   int err_total = 0;
   int tests_run = 0;
   int cyc_cnt = 0;
   int n;
   logic [3:0] ofs [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
   logic [7:0] rv [5] = '{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
   sacs_sar_t lv [4] = '{11'h2a5, 11'h7ff, 11'h003, 11'h004};
   logic [7:0] ex8 [4] = '{8'h55, 8'hff, 8'h00, 8'h01};

   sacs_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .stop_mode_i(stop),
      .alt_clk_i(alt), .async_clk_i(asy), .comp_i(comp), .conv_on_o(conv_o), .sample_o(smp_o),
      .input_isolate_o(iso_o), .low_power_o(lp_o), .async_clk_req_o(areq_o), .channel_o(ch_o),
      .dac_trial_o(trial));
   sacs_analog_model ana (.dac_trial_i(trial), .level_i(level), .comp_o(comp));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      alt = 1'b0;
      forever #50 alt = ~alt;
   end
   // Generator only runs while the block asks for it
   initial begin
      asy = 1'b0;
      forever #37 asy = areq_o ? ~asy : 1'b0;
   end

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("Error at %0t ns: seen %h, expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      sel <= 4'hf;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   // Polling the status register has no side effect on the flag
   task automatic wait_done();
      n = 0;
      do begin
         wb(1'b0, SC, 8'h00);
         n++;
      end while (q[7] !== 1'b1 && n < 400);
   endtask : wait_done

   task automatic span(input int ex, input int tol);
      n = 0;
      @(posedge clk_i);
      while (conv_o === 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      chk((n >= ex - tol) && (n <= ex + tol), 1'b1);
   endtask : span

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 4'h0;
      sel = 4'h0;
      dat = 32'h0;
      stop = 1'b0;
      level = 11'h2a5;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(iso_o, 1'b1);
      for (int i = 0; i < 5; i++) begin
         rd(ofs[i], rv[i]);
      end
      $display("Test reset done");
      wb(1'b1, CK, 8'h90);
      chk(lp_o, 1'b1);
      rd(CK, 8'h90);
      for (int i = 0; i < 4; i++) begin
         level = lv[i];
         wb(1'b1, SC, 8'h43);
         chk(ch_o, 5'h03);
         wait_done();
         chk(irq_o, 1'b1);
         chk(conv_o, 1'b0);
         rd(RH, 8'h00);
         chk(irq_o, 1'b0);
         rd(RL, ex8[i]);
         rd(SC, 8'h43);
      end
      wb(1'b1, SC, 8'h03);
      wait_done();
      chk(irq_o, 1'b0);
      $display("Test single 8-bit done");
      wb(1'b1, SC, 8'h23);
      wait_done();
      rd(RH, 8'h00);
      level = 11'h100;
      repeat (40) @(posedge clk_i);
      rd(RL, 8'h20);
      wb(1'b1, CK, 8'h14);
      repeat (40) @(posedge clk_i);
      chk(conv_o, 1'b0);
      $display("Test continuous 8-bit done");
      level = 11'h2a5;
      wb(1'b1, SC, 8'h23);
      wait_done();
      rd(RH, 8'h01);
      level = 11'h100;
      repeat (40) @(posedge clk_i);
      rd(RL, 8'h53);
      repeat (40) @(posedge clk_i);
      rd(RH, 8'h00);
      rd(RL, 8'h80);
      $display("Test interlock done");
      stop <= 1'b1;
      level = 11'h7ff;
      repeat (3) @(posedge clk_i);
      chk(conv_o, 1'b0);
      repeat (40) @(posedge clk_i);
      stop <= 1'b0;
      repeat (40) @(posedge clk_i);
      chk(conv_o, 1'b0);
      rd(RH, 8'h00);
      rd(RL, 8'h80);
      wb(1'b1, SC, 8'h3f);
      repeat (40) @(posedge clk_i);
      chk(conv_o, 1'b0);
      chk(iso_o, 1'b1);
      $display("Test stop done");
      wb(1'b1, SC, 8'h03);
      repeat (5) @(posedge clk_i);
      wb(1'b1, SC, 8'h03);
      chk(smp_o, 1'b1);
      span(14, 4);
      wait_done();
      rd(RH, 8'h03);
      rd(RL, 8'hff);
      $display("Test abort done");
      for (int d = 0; d < 4; d++) begin
         for (int l = 0; l < 2; l++) begin
            wb(1'b1, CK, {1'b0, d[1:0], 1'b1, 2'b00, l[0], 1'b0});
            wb(1'b1, SC, 8'h03);
            span((l ? 35 : 15) * (1 << d) - 1, (1 << d) + 3);
         end
      end
      repeat (20) @(posedge clk_i);
      chk(conv_o, 1'b0);
      wb(1'b1, CK, 8'h18);
      wb(1'b1, SC, 8'h03);
      wait_done();
      rd(RH, 8'h00);
      wb(1'b1, SC, 8'h3f);
      rd(SC, 8'h1f);
      rd(RL, 8'hff);
      $display("Test divider done");
      wb(1'b1, CK, 8'h00);
      wb(1'b1, SC, 8'h03);
      span(59, 8);
      wb(1'b1, CK, 8'h11);
      wb(1'b1, SC, 8'h03);
      @(posedge clk_i);
      chk(areq_o, 1'b1);
      stop <= 1'b1;
      span(44, 12);
      chk(areq_o, 1'b0);
      wait_done();
      stop <= 1'b0;
      $display("Test clock source done");
      complete_run();
   end
endmodule : tb_sacs_top
